/* File: rtl/ssf_front_end.v */
// Serial link front end of a byte-wide memory, target side
`timescale 1ns/10ps
`default_nettype none
`include "ssf_map.vh"
module ssf_front_end #(
  parameter AW = 15,
  parameter DW = 8
) (
  input  wire          sys_clk,
  input  wire          arst_n,
  input  wire          device_select_n,
  input  wire          sck,
  input  wire          serial_in,
  input  wire          pause_n,
  output reg           serial_out,
  output wire          serial_out_oe,
  output reg  [AW-1:0] mem_addr,
  output reg           mem_rd_req,
  input  wire [DW-1:0] mem_rd_data,
  output reg           mem_wr_req,
  output reg  [DW-1:0] mem_wr_data,
  input  wire          mem_busy,
  output reg  [DW-1:0] status_value,
  output reg           standby
);

  ////////////////////////////////////////////////////////////////////////////
  // Sequence states

  localparam [2:0] ST_CMD  = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_RD   = 3'd2;
  localparam [2:0] ST_WR   = 3'd3;
  localparam [2:0] ST_SRD  = 3'd4;
  localparam [2:0] ST_SWR  = 3'd5;
  localparam [2:0] ST_SKIP = 3'd6;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and clock edge detection

  wire [3:0] pins_s;
  wire       cs_n_s;
  wire       sck_s;
  wire       si_s;
  wire       pause_n_s;
  reg        sck_d_r;
  wire       sck_rise;
  wire       sck_fall;
  wire       selected;
  wire       pause_now;
  wire       paused;
  wire       act_rise;
  wire       act_fall;

  ssf_sync #(
    .WIDTH   (4),
    .RST_VAL (4'h9)
  ) u_sync (
    .clk      (sys_clk),
    .arst_n   (arst_n),
    .async_in ({device_select_n, sck, serial_in, pause_n}),
    .sync_out (pins_s)
  );

  assign cs_n_s    = pins_s[3];
  assign sck_s     = pins_s[2];
  assign si_s      = pins_s[1];
  assign pause_n_s = pins_s[0];
  assign selected  = ~cs_n_s;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
    end
  end

  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pause handling

  reg started_r;

  ssf_pause_ctl u_pause (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .selected  (selected),
    .started   (started_r),
    .pause_n_s (pause_n_s),
    .sck_s     (sck_s),
    .pause_now (pause_now),
    .paused    (paused)
  );

  // Edges seen while paused are dropped, sequence state is untouched
  assign act_rise = selected & sck_rise & ~pause_now;
  // The fall that carries a delayed pause still shifts, so resume loses no bit
  assign act_fall = selected & sck_fall & ~paused;

  ////////////////////////////////////////////////////////////////////////////
  // Receive sequencer

  reg  [2:0]    state_r;
  reg  [2:0]    state_nxt;
  reg  [4:0]    cnt_r;
  reg  [4:0]    cnt_nxt;
  reg  [15:0]   shin_r;
  wire [15:0]   shin_nxt;
  reg           is_rd_r;
  reg           is_rd_nxt;
  reg  [AW-1:0] addr_r;
  reg  [AW-1:0] addr_nxt;
  reg  [AW-1:0] addr_inc;
  reg           rd_go;
  reg           wr_go;
  reg           swr_go;
  reg           srd_go;

  assign shin_nxt = {shin_r[14:0], si_s};

  always @* begin
    addr_inc = addr_r + {{(AW-1){1'b0}}, 1'b1};
    if (addr_r == `SSF_ADDR_TOP) begin
      addr_inc = `SSF_ADDR_ZERO;
    end
  end

  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    is_rd_nxt = is_rd_r;
    addr_nxt  = addr_r;
    rd_go     = 1'b0;
    wr_go     = 1'b0;
    swr_go    = 1'b0;
    srd_go    = 1'b0;
    if (act_rise) begin
      cnt_nxt = cnt_r + 5'h01;
      case (state_r)
        ST_CMD: begin
          if (cnt_r == `SSF_CMD_LAST_BIT) begin
            cnt_nxt = 5'h00;
            case (shin_nxt[7:0])
              `SSF_CMD_MEM_RD: begin
                state_nxt = ST_ADDR;
                is_rd_nxt = 1'b1;
              end
              `SSF_CMD_MEM_WR: begin
                state_nxt = ST_ADDR;
                is_rd_nxt = 1'b0;
              end
              `SSF_CMD_STAT_RD: begin
                state_nxt = ST_SRD;
                srd_go    = 1'b1;
              end
              `SSF_CMD_STAT_WR: begin
                state_nxt = ST_SWR;
              end
              default: begin
                state_nxt = ST_SKIP;
              end
            endcase
          end
        end
        ST_ADDR: begin
          if (cnt_r == `SSF_ADDR_LAST_BIT) begin
            cnt_nxt  = 5'h00;
            // Top address bit is a don't care
            addr_nxt = shin_nxt[AW-1:0];
            if (is_rd_r) begin
              state_nxt = ST_RD;
              rd_go     = 1'b1;
            end else begin
              state_nxt = ST_WR;
            end
          end
        end
        ST_RD: begin
          if (cnt_r == `SSF_BYTE_LAST_BIT) begin
            cnt_nxt  = 5'h00;
            addr_nxt = addr_inc;
            rd_go    = 1'b1;
          end
        end
        ST_WR: begin
          if (cnt_r == `SSF_BYTE_LAST_BIT) begin
            cnt_nxt  = 5'h00;
            addr_nxt = addr_inc;
            wr_go    = 1'b1;
          end
        end
        ST_SWR: begin
          if (cnt_r == `SSF_BYTE_LAST_BIT) begin
            cnt_nxt   = 5'h00;
            swr_go    = 1'b1;
            state_nxt = ST_SKIP;
          end
        end
        ST_SRD: begin
          if (cnt_r == `SSF_BYTE_LAST_BIT) begin
            cnt_nxt = 5'h00;
          end
        end
        default: begin
          cnt_nxt = 5'h00;
        end
      endcase
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= ST_CMD;
      cnt_r     <= 5'h00;
      shin_r    <= 16'h0000;
      is_rd_r   <= 1'b0;
      addr_r    <= `SSF_ADDR_ZERO;
      started_r <= 1'b0;
    end else if (!selected) begin
      // Partial bits are thrown away on deselect
      state_r   <= ST_CMD;
      cnt_r     <= 5'h00;
      shin_r    <= 16'h0000;
      started_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      is_rd_r <= is_rd_nxt;
      addr_r  <= addr_nxt;
      if (act_rise) begin
        shin_r    <= shin_nxt;
        started_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory and status requests

  // A completed byte commits even if select rises right after
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_addr     <= `SSF_ADDR_ZERO;
      mem_rd_req   <= 1'b0;
      mem_wr_req   <= 1'b0;
      mem_wr_data  <= {DW{1'b0}};
      status_value <= `SSF_STATUS_RST;
    end else begin
      mem_rd_req <= rd_go;
      mem_wr_req <= wr_go;
      if (rd_go) begin
        mem_addr <= addr_nxt;
      end else if (wr_go) begin
        mem_addr    <= addr_r;
        mem_wr_data <= shin_nxt[DW-1:0];
      end
      if (swr_go) begin
        status_value <= shin_nxt[DW-1:0];
      end
    end
  end

  // Standby waits for a running write cycle to finish
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      standby <= 1'b1;
    end else begin
      standby <= cs_n_s & ~mem_busy & ~mem_wr_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path

  reg [DW-1:0] tx_buf_r;
  reg [DW-1:0] tx_sh_r;
  reg [2:0]    tx_cnt_r;
  reg          rd_pend_r;
  reg          out_act_r;
  wire         tx_phase;

  assign tx_phase = (state_r == ST_RD) | (state_r == ST_SRD);

  // Read data assumed valid one cycle after the request
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_pend_r <= 1'b0;
      tx_buf_r  <= {DW{1'b0}};
    end else begin
      rd_pend_r <= mem_rd_req;
      if (rd_pend_r) begin
        tx_buf_r <= mem_rd_data;
      end else if (srd_go) begin
        tx_buf_r <= status_value;
      end
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_out <= 1'b0;
      tx_sh_r    <= {DW{1'b0}};
      tx_cnt_r   <= 3'h0;
      out_act_r  <= 1'b0;
    end else if (!selected) begin
      tx_cnt_r  <= 3'h0;
      out_act_r <= 1'b0;
    end else if (act_fall && tx_phase) begin
      out_act_r <= 1'b1;
      tx_cnt_r  <= tx_cnt_r + 3'h1;
      if (tx_cnt_r == 3'h0) begin
        serial_out <= tx_buf_r[DW-1];
        tx_sh_r    <= {tx_buf_r[DW-2:0], 1'b0};
      end else begin
        serial_out <= tx_sh_r[DW-1];
        tx_sh_r    <= {tx_sh_r[DW-2:0], 1'b0};
      end
    end
  end

  // Pause level gates the driver directly, ahead of the pause itself
  assign serial_out_oe = selected & out_act_r & pause_n_s & ~paused;

endmodule // ssf_front_end
`default_nettype wire

/* File: rtl/ssf_pause_ctl.v */
// Pause tracking for the serial front end
`timescale 1ns/10ps
`default_nettype none
module ssf_pause_ctl (
  input  wire sys_clk,
  input  wire arst_n,
  input  wire selected,
  input  wire started,
  input  wire pause_n_s,
  input  wire sck_s,
  output wire pause_now,
  output wire paused
);
  reg  paused_r;
  reg  paused_nxt;
  wire enter;

  // Low clock level covers both the immediate case and the wait for a fall
  assign enter = selected & started & ~pause_n_s & ~sck_s;

  always @* begin
    paused_nxt = paused_r;
    if (!selected) begin
      paused_nxt = 1'b0;
    end else if (paused_r) begin
      if (pause_n_s && !sck_s) begin
        paused_nxt = 1'b0;
      end
    end else if (enter) begin
      paused_nxt = 1'b1;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      paused_r <= 1'b0;
    end else begin
      paused_r <= paused_nxt;
    end
  end

  // Entry cycle already blocks any rise seen with it
  assign pause_now = paused_r | enter;
  assign paused    = paused_r;
endmodule // ssf_pause_ctl
`default_nettype wire

/* File: rtl/ssf_sync.v */
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module ssf_sync #(
  parameter             WIDTH   = 4,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             arst_n,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_r;
      reg stable_r;
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_r   <= RST_VAL[g];
          stable_r <= RST_VAL[g];
        end else begin
          meta_r   <= async_in[g];
          stable_r <= meta_r;
        end
      end
      assign sync_out[g] = stable_r;
    end
  endgenerate
endmodule // ssf_sync
`default_nettype wire

/* File: shared/ssf_map.vh */
// Constants for the serial memory front end
// Function
// - Select low makes the device active; select high puts it in standby.
// - A write cycle already begun completes before standby is entered.
// - Serial output is never driven while select is high.
// - Instruction, address and data bits are captured on rising serial clock.
// - Serial output changes only after a falling serial clock edge.
// - Pause after a sequence started suspends it and keeps its state.
// - Pause falling while serial clock is low takes effect at once.
// - Pause falling while serial clock is high waits for next falling edge.
// - While paused, serial input and clock edges shift nothing.
// - While paused, serial output is not driven.
// - Lowering pause stops driving serial output at once, any clock level.
// - Everything is shifted most significant bit first.
// - Codes: memory read 03, memory write 02, status read 05, status write 01.
// - Memory commands carry a 16-bit address whose top bit is ignored.
// - Burst address advances after each byte and wraps from top to zero.
`ifndef SSF_MAP_VH
`define SSF_MAP_VH

`define SSF_CMD_MEM_RD    8'h03
`define SSF_CMD_MEM_WR    8'h02
`define SSF_CMD_STAT_RD   8'h05
`define SSF_CMD_STAT_WR   8'h01

`define SSF_CMD_LAST_BIT  5'h07
`define SSF_ADDR_LAST_BIT 5'h0f
`define SSF_BYTE_LAST_BIT 5'h07

`define SSF_ADDR_TOP      15'h7fff
`define SSF_ADDR_ZERO     15'h0000
`define SSF_STATUS_RST    8'h00

`endif

/* File: sim/ssf_fe_monitor.sv */
// Assertion checker on the ports of the serial memory front end
`timescale 1ns/10ps
`default_nettype none
module ssf_fe_monitor #(
  parameter AW = 15
) (
  input wire logic          sys_clk,
  input wire logic          arst_n,
  input wire logic          device_select_n,
  input wire logic          sck,
  input wire logic          pause_n,
  input wire logic          serial_out,
  input wire logic          serial_out_oe,
  input wire logic [AW-1:0] mem_addr,
  input wire logic          mem_rd_req,
  input wire logic          mem_wr_req,
  input wire logic          mem_busy,
  input wire logic [7:0]    status_value,
  input wire logic          standby
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  logic [AW-1:0] last_r;
  logic          have_r;

  // Last array address of this selection, cleared on deselect
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_r <= '0;
      have_r <= 1'b0;
    end else if (device_select_n) begin
      have_r <= 1'b0;
    end else if (mem_rd_req || mem_wr_req) begin
      last_r <= mem_addr;
      have_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_oe_desel: assert property (device_select_n [*4] |-> !serial_out_oe)
    else $error("output driven while deselected");
  chk_oe_pause: assert property (!pause_n [*4] |-> !serial_out_oe)
    else $error("output driven while pause low");
  chk_so_edge: assert property ($changed(serial_out) |-> !$past(sck, 2))
    else $error("output changed away from a clock fall");
  chk_standby_sel: assert property ((device_select_n && !mem_busy) [*5] |-> standby)
    else $error("no standby while deselected");
  chk_busy_wake: assert property (mem_busy && $past(mem_busy) |-> !standby)
    else $error("standby during write cycle");
  chk_pause_freeze: assert property (!pause_n [*8] |-> !mem_rd_req && !mem_wr_req && $stable(serial_out))
    else $error("activity while paused");
  chk_status_sel: assert property ($changed(status_value) |-> !$past(device_select_n, 4))
    else $error("status changed without selection");
  chk_addr_step: assert property ((mem_rd_req || mem_wr_req) && have_r |-> mem_addr == last_r + 1'b1)
    else $error("burst address did not step by one");

  cov_write: cover property (mem_wr_req);
  cov_read: cover property (mem_rd_req);
  cov_pause: cover property (!pause_n [*8]);
endmodule // ssf_fe_monitor

bind ssf_front_end ssf_fe_monitor #(.AW(AW)) u_ssf_fe_monitor (
  .sys_clk         (sys_clk),
  .arst_n          (arst_n),
  .device_select_n (device_select_n),
  .sck             (sck),
  .pause_n         (pause_n),
  .serial_out      (serial_out),
  .serial_out_oe   (serial_out_oe),
  .mem_addr        (mem_addr),
  .mem_rd_req      (mem_rd_req),
  .mem_wr_req      (mem_wr_req),
  .mem_busy        (mem_busy),
  .status_value    (status_value),
  .standby         (standby)
);
`default_nettype wire

/* File: sim/ssf_host_model.sv */
// Host link controller model driving the serial memory front end
`timescale 1ns/10ps
`default_nettype none
module ssf_host_model (
  input  wire logic sys_clk,
  input  wire logic serial_out,
  input  wire logic serial_out_oe,
  output var  logic device_select_n,
  output var  logic sck,
  output var  logic serial_in,
  output var  logic pause_n
);
  wire so_wire;

  // Released line shows the inverse so a stray read cannot match
  assign so_wire = serial_out_oe ? serial_out : ~serial_out;

  initial begin
    device_select_n = 1'b1;
    sck = 1'b0;
    serial_in = 1'b0;
    pause_n = 1'b1;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Pause with clock low, wiggle the link, resume with clock low
  task automatic pause_wiggle;
    pause_n = 1'b0;
    wait_n(6);
    repeat (4) begin
      sck = ~sck;
      serial_in = ~serial_in;
      wait_n(4);
    end
    pause_n = 1'b1;
    wait_n(4);
  endtask

  // Mode 1 drops pause in the high phase, mode 2 in the low phase
  task automatic xfer_bit(input logic b, input logic [1:0] hm, output logic r);
    if (hm == 2'd2) begin
      // Let the last fall settle so the pause lands in the low phase
      wait_n(2);
      pause_wiggle();
    end
    serial_in = b;
    wait_n(4);
    r = so_wire;
    sck = 1'b1;
    wait_n(2);
    if (hm == 2'd1) pause_n = 1'b0;
    wait_n(2);
    sck = 1'b0;
    if (hm == 2'd1) pause_wiggle();
  endtask

  task automatic xfer_byte(input logic [7:0] tx, input int at, input logic [1:0] hm,
                           output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) xfer_bit(tx[i], (i == at) ? hm : 2'd0, rx[i]);
  endtask

  task automatic select(input logic on);
    wait_n(4);
    device_select_n = ~on;
    serial_in = ~serial_in;
    wait_n(4);
  endtask
endmodule // ssf_host_model
`default_nettype wire

/* File: sim/tb_ssf_front_end.sv */
// Self-checking bench for the serial memory front end
`timescale 1ns/10ps
`default_nettype none
`include "ssf_map.vh"
module tb_ssf_front_end;
  logic       sys_clk;
  logic       arst_n;
  wire        device_select_n;
  wire        sck;
  wire        serial_in;
  wire        pause_n;
  wire        serial_out;
  wire        serial_out_oe;
  wire [14:0] mem_addr;
  wire        mem_rd_req;
  logic [7:0] mem_rd_data;
  wire        mem_wr_req;
  wire [7:0]  mem_wr_data;
  logic       mem_busy;
  wire [7:0]  status_value;
  wire        standby;
  logic [7:0] mem [0:32767];
  logic [1:0] busy_cnt;
  logic [7:0] rx_r;
  logic       rb;
  int         n_mismatch;
  int         checked;

  ssf_front_end u_ssf_front_end (
    .sys_clk(sys_clk), .arst_n(arst_n), .device_select_n(device_select_n), .sck(sck),
    .serial_in(serial_in), .pause_n(pause_n), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .mem_addr(mem_addr), .mem_rd_req(mem_rd_req),
    .mem_rd_data(mem_rd_data), .mem_wr_req(mem_wr_req), .mem_wr_data(mem_wr_data),
    .mem_busy(mem_busy), .status_value(status_value), .standby(standby)
  );
  ssf_host_model u_ssf_host_model (
    .sys_clk(sys_clk), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .device_select_n(device_select_n), .sck(sck), .serial_in(serial_in), .pause_n(pause_n)
  );

  always #5 sys_clk = ~sys_clk;

  // Array model: read data one cycle after request, short busy after write
  always @(negedge sys_clk) begin
    if (mem_rd_req) mem_rd_data <= mem[mem_addr];
    if (mem_wr_req) mem[mem_addr] <= mem_wr_data;
    if (mem_wr_req) busy_cnt <= 2'd3;
    else if (busy_cnt != 2'd0) busy_cnt <= busy_cnt - 2'd1;
    mem_busy <= mem_wr_req || (busy_cnt != 2'd0);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tx(input logic [7:0] b, input int at, input logic [1:0] hm);
    u_ssf_host_model.xfer_byte(b, at, hm, rx_r);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Burst write over the top address with pauses, then read back with pauses
  task automatic t_burst_wrap;
    u_ssf_host_model.select(1'b1);
    tx(`SSF_CMD_MEM_WR, 9, 2'd0);
    tx(8'hff, 9, 2'd0);
    tx(8'hfe, 9, 2'd0);
    tx(8'ha5, 3, 2'd1);
    tx(8'h3c, 5, 2'd2);
    tx(8'he1, 9, 2'd0);
    u_ssf_host_model.select(1'b0);
    cmp_data(mem[15'h7ffe], 8'ha5);
    cmp_data(mem[15'h7fff], 8'h3c);
    cmp_data(mem[15'h0000], 8'he1);
    u_ssf_host_model.select(1'b1);
    tx(`SSF_CMD_MEM_RD, 9, 2'd0);
    tx(8'h7f, 9, 2'd0);
    tx(8'hfe, 9, 2'd0);
    tx(8'h00, 9, 2'd0);
    cmp_data(rx_r, 8'ha5);
    tx(8'h00, 3, 2'd1);
    cmp_data(rx_r, 8'h3c);
    tx(8'h00, 5, 2'd2);
    cmp_data(rx_r, 8'he1);
    u_ssf_host_model.select(1'b0);
  endtask

  // Status write ignores extra bytes; status read repeats the byte
  task automatic t_status;
    u_ssf_host_model.select(1'b1);
    cmp_flag(standby, 1'b0);
    tx(`SSF_CMD_STAT_WR, 9, 2'd0);
    tx(8'h5a, 9, 2'd0);
    tx(8'hc3, 9, 2'd0);
    u_ssf_host_model.select(1'b0);
    cmp_data(status_value, 8'h5a);
    u_ssf_host_model.wait_n(4);
    cmp_flag(standby, 1'b1);
    cmp_flag(serial_out_oe, 1'b0);
    u_ssf_host_model.select(1'b1);
    tx(`SSF_CMD_STAT_RD, 9, 2'd0);
    tx(8'h00, 9, 2'd0);
    cmp_data(rx_r, 8'h5a);
    tx(8'h00, 9, 2'd0);
    cmp_data(rx_r, 8'h5a);
    u_ssf_host_model.select(1'b0);
  endtask

  // Half a data byte then deselect: nothing stored, next frame is a command
  task automatic t_partial;
    u_ssf_host_model.select(1'b1);
    tx(`SSF_CMD_MEM_WR, 9, 2'd0);
    tx(8'h00, 9, 2'd0);
    tx(8'h20, 9, 2'd0);
    repeat (4) u_ssf_host_model.xfer_bit(1'b1, 2'd0, rb);
    u_ssf_host_model.select(1'b0);
    u_ssf_host_model.select(1'b1);
    tx(`SSF_CMD_STAT_RD, 9, 2'd0);
    tx(8'h00, 9, 2'd0);
    cmp_data(rx_r, 8'h5a);
    u_ssf_host_model.select(1'b0);
    cmp_data(mem[15'h0020], 8'h00);
  endtask

  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    mem_rd_data = 8'h00;
    mem_busy = 1'b0;
    busy_cnt = 2'd0;
    n_mismatch = 0;
    checked = 0;
    for (int i = 0; i < 32768; i++) mem[i] = 8'h00;
    repeat (2) @(negedge sys_clk);
    arst_n = 1'b1;
    t_burst_wrap();
    t_status();
    t_partial();
    finish_test();
  end

  // Whole run is under two thousand cycles; far beyond that means a hang
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
endmodule // tb_ssf_front_end
`default_nettype wire
